// ### rtl/diag_aggregator.sv
// Diagnostic aggregator: filtering, output locking, diag image and alarms
// Contract
// - Actuator supply fault locks all active outputs until controller resets.
// - Actuator supply fault reported after fixed 300 ms filter.
// - Sensor supply out of window sets sensor-low bit and red indicator.
// - Sensor supply fault reported immediately, outputs untouched.
// - Diagnostic image holds up to five bytes, first to last.
// - 16-input layout: sensor short bit 2, sensor low bit 0, slots byte 2.
// - 16-output layout: flags byte 1, zero bytes 2-3, channel pairs bytes 4-5.
// - Mixed layout: all four flags, slots 4..1, channel pairs 8..5.
// - Alarms only sent while diagnostics enabled.
// - Diagnostic alarm on overload, short circuit and undervoltage.
// - Alarm on fault appearing and on fault going away.
// - Records use block version 0x0101 and structure id 0x8000.
// - Undervoltage entries use channel 0x8000 and error 0x0002.
// - Slot faults use slot number and short-circuit error codes.
// - One channel entry per fault present.
// - Short faults filtered by configurable 0-255 ms window; channel faults only inside that window after a switching edge, else fixed 100 ms.
// - Output fault locks both active channels of slot, or the one.
// - Actuator supply out of window sets actuator-low bit, except in the 16-input layout.
`timescale 1ns/1ps
`default_nettype none
module diag_aggregator
    import diag_pkg::*;
#(
    parameter int CYC_MS = CYC_PER_MS,
    parameter variant_type VARIANT = VAR_16DO
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic [1:0] i_variant_unused,
    input wire logic [7:0] i_surv_ms,
    input wire logic i_diag_enable,
    input wire logic i_sensor_supply_bad,
    input wire logic i_actuator_supply_bad,
    input wire logic [NUM_SLOTS-1:0] i_sensor_short_raw,
    input wire logic [2*NUM_SLOTS-1:0] i_chan_fault_raw,
    input wire logic [2*NUM_SLOTS-1:0] i_out_target,
    input wire logic [2*NUM_SLOTS-1:0] i_lock_reset,
    input wire logic i_alarm_ack,
    input wire logic [4:0] i_entry_idx,
    output logic [2*NUM_SLOTS-1:0] o_out_drive,
    output logic [2*NUM_SLOTS-1:0] o_lock,
    output logic [8*NUM_DIAG_BYTES-1:0] o_diag_image,
    output logic [2:0] o_diag_len,
    output logic o_sensor_led_red,
    output logic o_actuator_led_red,
    output logic o_alarm_valid,
    output logic o_alarm_incoming,
    output logic [15:0] o_alarm_chan_num,
    output logic [15:0] o_alarm_err_type,
    output logic [15:0] o_block_version,
    output logic [15:0] o_user_struct_id,
    output logic [NUM_FAULTS-1:0] o_fault_present,
    output logic [15:0] o_entry_chan_num,
    output logic [15:0] o_entry_err_type,
    output logic [15:0] o_entry_props
);
    fault_if flt ();

    logic [2*NUM_SLOTS-1:0] lock_r;
    logic [2*NUM_SLOTS-1:0] chan_flt;
    logic [NUM_FAULTS-1:0] cur;
    logic [NUM_FAULTS-1:0] prev_r;
    logic [NUM_FAULTS-1:0] pend_r;
    logic [NUM_FAULTS-1:0] pend_nxt;
    logic [NUM_FAULTS-1:0] dir_r;
    logic [NUM_FAULTS-1:0] pend_dir_nxt;
    logic [4:0] pick;
    logic [4:0] sent_r;
    logic pick_ok;
    logic [7:0] byte1;
    logic [7:0] slot_flags;
    logic [8*NUM_DIAG_BYTES-1:0] img;
    logic [15:0] alm_chan;
    logic [15:0] alm_err;
    logic [15:0] ent_chan;
    logic [15:0] ent_err;
    alm_state_type state_r;

    fault_filter #(
        .CYC_MS(CYC_MS)
    ) u_filter (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_surv_ms(i_surv_ms),
        .i_act_low_raw(i_actuator_supply_bad),
        .i_sshort_raw(i_sensor_short_raw),
        .i_chan_raw(i_chan_fault_raw),
        .i_out_state(o_out_drive),
        .flt(flt)
    );

    genvar s;
    for (s = 0; s < NUM_SLOTS; s++) begin : g_slot
        assign chan_flt[2*s] = flt.chan_a_fault[s];
        assign chan_flt[2*s+1] = flt.chan_b_fault[s];
        // Either channel fault locks every active channel of the slot
        always_ff @(posedge i_clk) begin
            if (i_rst) begin
                lock_r[2*s+1:2*s] <= '0;
            end else begin
                if (flt.chan_a_fault[s] || flt.chan_b_fault[s]) begin
                    lock_r[2*s+1:2*s] <= lock_r[2*s+1:2*s] | o_out_drive[2*s+1:2*s];
                end else if (flt.actuator_low) begin
                    lock_r[2*s+1:2*s] <= lock_r[2*s+1:2*s] | o_out_drive[2*s+1:2*s];
                end else begin
                    // Only controller reset releases a lock
                    lock_r[2*s+1:2*s] <= lock_r[2*s+1:2*s] & ~i_lock_reset[2*s+1:2*s];
                end
            end
        end
    end

    // Sensor supply fault does not feed the lock path
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_out_drive <= '0;
        end else begin
            // Mask in the same register so a locked channel never pulses on
            o_out_drive <= i_out_target & ~lock_r;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_lock <= '0;
        end else begin
            o_lock <= lock_r;
        end
    end

    // Sensor low unfiltered
    assign cur = {chan_flt, flt.sensor_short, flt.actuator_low, i_sensor_supply_bad};

    always_comb begin
        byte1 = 8'h00;
        byte1[BIT_SENSOR_LOW] = i_sensor_supply_bad;
        byte1[BIT_ACT_LOW] = (VARIANT != VAR_16DI) && flt.actuator_low;
        byte1[BIT_SENSOR_SHORT] = (VARIANT != VAR_16DO) && |flt.sensor_short;
        byte1[BIT_ACT_SHORT] = (VARIANT != VAR_16DI) && |chan_flt;
        slot_flags = flt.sensor_short;
        img = '0;
        o_diag_len = 3'h2;
        // Byte 1 in the low lane, bytes presented first to last
        case (VARIANT)
            VAR_16DI: begin
                img[15:0] = {slot_flags, byte1};
                o_diag_len = 3'h2;
            end
            VAR_16DO: begin
                img[39:0] = {chan_flt[15:8], chan_flt[7:0], 16'h0000, byte1};
                o_diag_len = 3'h5;
            end
            default: begin
                img[23:0] = {chan_flt[15:8], 4'h0, slot_flags[3:0], byte1};
                o_diag_len = 3'h3;
            end
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_diag_image <= '0;
            o_fault_present <= '0;
        end else begin
            o_diag_image <= img;
            o_fault_present <= cur; // Entry per set bit
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_sensor_led_red <= 1'b0;
            o_actuator_led_red <= 1'b0;
        end else begin
            o_sensor_led_red <= i_sensor_supply_bad;
            o_actuator_led_red <= flt.actuator_low;
        end
    end

    // Every edge of every fault becomes a pending alarm while diagnostics are enabled
    always_comb begin
        pend_nxt = pend_r;
        pend_dir_nxt = dir_r;
        pick = '0;
        pick_ok = 1'b0;
        for (int i = NUM_FAULTS - 1; i >= 0; i--) begin
            if (pend_r[i]) begin
                pick = 5'(i);
                pick_ok = 1'b1;
            end
        end
        // Clear the index on the wire, not the lowest one pending now
        if (state_r == ALM_SEND && i_alarm_ack) begin
            pend_nxt[sent_r] = 1'b0;
        end
        // New edge wins over the clear in the same cycle
        for (int i = 0; i < NUM_FAULTS; i++) begin
            if (cur[i] != prev_r[i]) begin
                pend_nxt[i] = i_diag_enable; // Suppressed when off
                pend_dir_nxt[i] = cur[i];
            end
        end
        if (!i_diag_enable) begin
            pend_nxt = '0;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            prev_r <= '0;
        end else begin
            prev_r <= cur;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            pend_r <= '0;
        end else begin
            pend_r <= pend_nxt;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            dir_r <= '0;
        end else begin
            dir_r <= pend_dir_nxt;
        end
    end

    diag_record_enc u_alm_enc (
        .i_idx(pick),
        .o_chan_num(alm_chan),
        .o_err_type(alm_err)
    );

    diag_record_enc u_ent_enc (
        .i_idx(i_entry_idx),
        .o_chan_num(ent_chan),
        .o_err_type(ent_err)
    );

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            state_r <= ALM_IDLE;
            sent_r <= '0;
            o_alarm_valid <= 1'b0;
            o_alarm_incoming <= 1'b0;
            o_alarm_chan_num <= '0;
            o_alarm_err_type <= '0;
        end else begin
            case (state_r)
                ALM_IDLE: begin
                    if (pick_ok && i_diag_enable) begin
                        state_r <= ALM_SEND;
                        sent_r <= pick;
                        o_alarm_valid <= 1'b1;
                        o_alarm_incoming <= dir_r[pick];
                        o_alarm_chan_num <= alm_chan;
                        o_alarm_err_type <= alm_err;
                    end
                end
                default: begin
                    if (i_alarm_ack || !i_diag_enable) begin
                        state_r <= ALM_IDLE;
                        o_alarm_valid <= 1'b0;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_entry_chan_num <= '0;
            o_entry_err_type <= '0;
            o_entry_props <= '0;
        end else begin
            o_entry_chan_num <= ent_chan;
            o_entry_err_type <= ent_err;
            o_entry_props <= CHAN_PROPS;
        end
    end

    // Header reads zero in reset so a stale record is never taken as valid
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_block_version <= '0;
            o_user_struct_id <= '0;
        end else begin
            o_block_version <= BLOCK_VERSION;
            o_user_struct_id <= USER_STRUCT_ID;
        end
    end
endmodule
`default_nettype wire

// ### common/diag_pkg.sv
// Shared constants and types for the I/O module diagnostic aggregator
package diag_pkg;
    localparam int CLK_HZ = 200_000_000;
    localparam int MS_TIME = 1;
    localparam int CYC_PER_MS = CLK_HZ / 1000 * MS_TIME;
    localparam int ACT_FILT_MS = 300;
    localparam int STATIC_FILT_MS = 100;
    localparam logic [7:0] SURV_DEFAULT_MS = 8'h50;
    localparam int NUM_SLOTS = 8;
    localparam int NUM_DIAG_BYTES = 5;

    localparam logic [15:0] BLOCK_VERSION = 16'h0101;
    localparam logic [15:0] USER_STRUCT_ID = 16'h8000;
    localparam logic [15:0] CHAN_MODULE = 16'h8000;
    localparam logic [15:0] ERR_UNDERVOLT = 16'h0002;
    localparam logic [15:0] ERR_SENSOR_SHORT = 16'h0102;
    localparam logic [15:0] ERR_ACT_SHORT_A = 16'h0100;
    localparam logic [15:0] ERR_ACT_SHORT_B = 16'h0101;
    localparam logic [15:0] CHAN_PROPS = 16'h0000;

    localparam int BIT_SENSOR_LOW = 0;
    localparam int BIT_ACT_LOW = 1;
    localparam int BIT_SENSOR_SHORT = 2;
    localparam int BIT_ACT_SHORT = 3;

    // Fault source index: 0 sensor low, 1 actuator low, 2..9 sensor short, 10..25 chan A/B
    localparam int NUM_FAULTS = 26;
    localparam int FIDX_SSHORT = 2;
    localparam int FIDX_CHAN = 10;

    typedef enum logic [1:0] {
        VAR_16DI,
        VAR_16DO,
        VAR_8DI8DO
    } variant_type;

    typedef enum {
        ALM_IDLE,
        ALM_SEND
    } alm_state_type;
endpackage

// ### common/fault_if.sv
// Carrier of filtered fault flags between filter and aggregator
`timescale 1ns/1ps
`default_nettype none
interface fault_if;
    logic [diag_pkg::NUM_SLOTS-1:0] sensor_short;
    logic [diag_pkg::NUM_SLOTS-1:0] chan_a_fault;
    logic [diag_pkg::NUM_SLOTS-1:0] chan_b_fault;
    logic actuator_low;
    logic tick_ms;
    modport src (output sensor_short, chan_a_fault, chan_b_fault, actuator_low, tick_ms);
    modport dst (input sensor_short, chan_a_fault, chan_b_fault, actuator_low, tick_ms);
endinterface
`default_nettype wire

// ### rtl/fault_filter.sv
// Millisecond tick and per-fault debounce filters
`timescale 1ns/1ps
`default_nettype none
module fault_filter
    import diag_pkg::*;
#(
    parameter int CYC_MS = CYC_PER_MS
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic [7:0] i_surv_ms,
    input wire logic i_act_low_raw,
    input wire logic [NUM_SLOTS-1:0] i_sshort_raw,
    input wire logic [2*NUM_SLOTS-1:0] i_chan_raw,
    input wire logic [2*NUM_SLOTS-1:0] i_out_state,
    fault_if.src flt
);
    logic [31:0] pre_r;
    logic tick_r;
    logic [2*NUM_SLOTS-1:0] out_prev_r;
    logic [7:0] since_edge_r [2*NUM_SLOTS];
    logic [8:0] cnt_r [NUM_FAULTS];
    logic [NUM_FAULTS-1:0] raw;
    logic [NUM_FAULTS-1:0] flt_r;

    always_ff @(posedge i_clk) begin
        if (i_rst || pre_r == 32'(CYC_MS - 1)) begin
            pre_r <= '0;
        end else begin
            pre_r <= pre_r + 32'h1;
        end
    end

    always_ff @(posedge i_clk) begin
        tick_r <= !i_rst && pre_r == 32'(CYC_MS - 1);
    end

    always_ff @(posedge i_clk) begin
        out_prev_r <= i_rst ? '0 : i_out_state;
    end

    assign raw = {i_chan_raw, i_sshort_raw, i_act_low_raw, 1'b0};

    genvar g;
    for (g = 0; g < NUM_FAULTS; g++) begin : g_flt
        logic [8:0] lim;
        if (g == 1) begin : g_act
            assign lim = 9'(ACT_FILT_MS); // Fixed, ignores the timeout
        end else if (g >= FIDX_CHAN) begin : g_ch
            // Switching edge opens the configured window, else static filter
            always_ff @(posedge i_clk) begin
                if (i_rst || i_out_state[g-FIDX_CHAN] != out_prev_r[g-FIDX_CHAN]) begin
                    since_edge_r[g-FIDX_CHAN] <= '0;
                end else if (tick_r && since_edge_r[g-FIDX_CHAN] != 8'hff) begin
                    since_edge_r[g-FIDX_CHAN] <= since_edge_r[g-FIDX_CHAN] + 8'h1;
                end
            end
            assign lim = (since_edge_r[g-FIDX_CHAN] < i_surv_ms) ?
                         {1'b0, i_surv_ms} : 9'(STATIC_FILT_MS);
        end else begin : g_ss
            assign lim = {1'b0, i_surv_ms};
        end
        always_ff @(posedge i_clk) begin
            if (i_rst || !raw[g]) begin
                cnt_r[g] <= '0;
                flt_r[g] <= 1'b0; // Clears once fault gone
            end else if (cnt_r[g] >= lim) begin
                flt_r[g] <= 1'b1;
            end else if (tick_r) begin
                cnt_r[g] <= cnt_r[g] + 9'h1;
            end
        end
    end

    assign flt.actuator_low = flt_r[1];
    assign flt.sensor_short = flt_r[FIDX_CHAN-1:FIDX_SSHORT];
    for (g = 0; g < NUM_SLOTS; g++) begin : g_map
        assign flt.chan_a_fault[g] = flt_r[FIDX_CHAN+2*g];
        assign flt.chan_b_fault[g] = flt_r[FIDX_CHAN+2*g+1];
    end
    assign flt.tick_ms = tick_r;
endmodule
`default_nettype wire

// ### rtl/diag_record_enc.sv
// Encodes one channel diagnosis entry from a fault index
`timescale 1ns/1ps
`default_nettype none
module diag_record_enc
    import diag_pkg::*;
(
    input wire logic [4:0] i_idx,
    output logic [15:0] o_chan_num,
    output logic [15:0] o_err_type
);
    always_comb begin
        if (i_idx < 5'(FIDX_SSHORT)) begin
            o_chan_num = CHAN_MODULE; // Whole module
            o_err_type = ERR_UNDERVOLT;
        end else if (i_idx < 5'(FIDX_CHAN)) begin
            o_chan_num = 16'(i_idx - 5'(FIDX_SSHORT) + 5'h1);
            o_err_type = ERR_SENSOR_SHORT;
        end else begin
            o_chan_num = 16'(((i_idx - 5'(FIDX_CHAN)) >> 1) + 5'h1);
            o_err_type = i_idx[0] ? ERR_ACT_SHORT_B : ERR_ACT_SHORT_A;
        end
    end
endmodule
`default_nettype wire

// ### tb/diag_aggregator_chk.sv
// Port checker for the diagnostic aggregator
`timescale 1ns/1ps
`default_nettype none
module diag_aggregator_chk
    import diag_pkg::*;
#(
    parameter int CYC_MS = CYC_PER_MS
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_diag_enable,
    input wire logic i_sensor_supply_bad,
    input wire logic i_actuator_supply_bad,
    input wire logic [2*NUM_SLOTS-1:0] i_lock_reset,
    input wire logic i_alarm_ack,
    input wire logic [2*NUM_SLOTS-1:0] o_out_drive,
    input wire logic [2*NUM_SLOTS-1:0] o_lock,
    input wire logic o_sensor_led_red,
    input wire logic o_actuator_led_red,
    input wire logic o_alarm_valid,
    input wire logic o_alarm_incoming,
    input wire logic [15:0] o_alarm_chan_num,
    input wire logic [15:0] o_alarm_err_type,
    input wire logic [15:0] o_block_version,
    input wire logic [15:0] o_user_struct_id
);
    // Tick phase is free running, so one ms of slack below
    localparam int ACT_MIN = 299 * CYC_MS;
    localparam int ACT_MAX = 300 * CYC_MS + 8;
    logic [31:0] act_cnt_r;
    always_ff @(posedge i_clk) begin
        if (i_rst || !i_actuator_supply_bad) begin
            act_cnt_r <= '0;
        end else if (act_cnt_r != '1) begin
            act_cnt_r <= act_cnt_r + 32'h1;
        end
    end
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);
    property p_drive_mask;
        (o_out_drive & o_lock) == '0;
    endproperty
    a_drive_mask: assert property (p_drive_mask) else $error("locked channel driven");
    property p_sensor_set;
        i_sensor_supply_bad |=> o_sensor_led_red;
    endproperty
    a_sensor_set: assert property (p_sensor_set) else $error("sensor led late");
    property p_act_min;
        $rose(o_actuator_led_red) |-> act_cnt_r >= ACT_MIN;
    endproperty
    a_act_min: assert property (p_act_min) else $error("actuator fault early");
    property p_act_max;
        act_cnt_r > ACT_MAX |-> o_actuator_led_red;
    endproperty
    a_act_max: assert property (p_act_max) else $error("actuator fault late");
    property p_lock_hold;
        !$past(i_rst) |-> (~o_lock & $past(o_lock) & ~($past(i_lock_reset)
            | $past(i_lock_reset, 2))) == '0;
    endproperty
    a_lock_hold: assert property (p_lock_hold) else $error("lock dropped");
    property p_alarm_hold;
        o_alarm_valid && !i_alarm_ack && i_diag_enable |=> o_alarm_valid
            && $stable(o_alarm_chan_num) && $stable(o_alarm_err_type) && $stable(o_alarm_incoming);
    endproperty
    a_alarm_hold: assert property (p_alarm_hold) else $error("alarm not held");
    property p_alarm_off;
        !i_diag_enable |=> !o_alarm_valid;
    endproperty
    a_alarm_off: assert property (p_alarm_off) else $error("alarm while disabled");
    property p_module_err;
        o_alarm_valid && o_alarm_chan_num == 16'h8000 |-> o_alarm_err_type == 16'h0002;
    endproperty
    a_module_err: assert property (p_module_err) else $error("module error code");
    property p_record;
        !$past(i_rst) && !$past(i_rst, 2) && !$past(i_rst, 3)
            |-> o_block_version == 16'h0101 && o_user_struct_id == 16'h8000;
    endproperty
    a_record: assert property (p_record) else $error("record header");
endmodule
bind diag_aggregator diag_aggregator_chk #(.CYC_MS(CYC_MS)) u_chk (.*);
`default_nettype wire

// ### tb/plc_model.sv
// Controller model: alarm acknowledge and output targets
`timescale 1ns/1ps
`default_nettype none
module plc_model #(
    parameter int ACK_DLY = 2
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_valid,
    input wire logic i_incoming,
    input wire logic [15:0] i_chan,
    input wire logic [15:0] i_err,
    input wire logic i_act_red,
    input wire logic i_obey,
    input wire logic [15:0] i_cmd,
    output logic o_ack,
    output logic [15:0] o_target,
    output logic o_last_in,
    output logic [15:0] o_last_chan,
    output logic [15:0] o_last_err,
    output logic [7:0] o_count
);
    logic [3:0] wait_r;
    // Outputs off while obeying and the actuator red indicator is on
    assign o_target = (i_obey && i_act_red) ? 16'h0000 : i_cmd;
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_ack <= 1'b0;
            wait_r <= 4'h0;
            o_count <= 8'h00;
        end else if (o_ack) begin
            // Taken at the acknowledge edge
            o_ack <= 1'b0;
            wait_r <= 4'h0;
            o_last_in <= i_incoming;
            o_last_chan <= i_chan;
            o_last_err <= i_err;
            o_count <= o_count + 8'h01;
        end else if (i_valid) begin
            wait_r <= wait_r + 4'h1;
            o_ack <= int'(wait_r) >= ACK_DLY;
        end
    end
endmodule
`default_nettype wire

// ### tb/diag_aggregator_tb.sv
// Self-checking bench for the diagnostic aggregator
`timescale 1ns/1ps
`default_nettype none
module diag_aggregator_tb;
    import diag_pkg::*;
    localparam int CM = 4;
    logic i_clk = 1'b0;
    logic i_rst = 1'b1;
    logic [1:0] i_variant_unused = 2'h0;
    logic [7:0] i_surv_ms = 8'h05;
    logic i_diag_enable = 1'b1;
    logic i_sensor_supply_bad = 1'b0;
    logic i_actuator_supply_bad = 1'b0;
    logic [7:0] i_sensor_short_raw = 8'h00;
    logic [15:0] i_chan_fault_raw = 16'h0000;
    logic [15:0] i_lock_reset = 16'h0000;
    logic [4:0] i_entry_idx = 5'h00;
    logic [15:0] cmd = 16'h0000;
    logic obey = 1'b1;
    logic i_alarm_ack, last_in, o_sensor_led_red, o_actuator_led_red;
    logic o_alarm_valid, o_alarm_incoming;
    logic [15:0] i_out_target, last_chan, last_err, o_out_drive, o_lock, o_block_version;
    logic [15:0] o_alarm_chan_num, o_alarm_err_type, o_user_struct_id;
    logic [15:0] o_entry_chan_num, o_entry_err_type, o_entry_props;
    logic [39:0] o_diag_image;
    logic [2:0] o_diag_len;
    logic [25:0] o_fault_present;
    logic [7:0] count;
    int n_mismatch = 0;
    int num_checks = 0;
    int cyc = 0;
    diag_aggregator #(.CYC_MS(CM)) uut (.*);
    plc_model #(.ACK_DLY(2)) u_plc (.i_clk(i_clk), .i_rst(i_rst), .i_valid(o_alarm_valid),
        .i_incoming(o_alarm_incoming), .i_chan(o_alarm_chan_num), .i_err(o_alarm_err_type),
        .i_act_red(o_actuator_led_red), .i_obey(obey), .i_cmd(cmd), .o_ack(i_alarm_ack),
        .o_target(i_out_target), .o_last_in(last_in), .o_last_chan(last_chan),
        .o_last_err(last_err), .o_count(count));
    task automatic chk(input logic [39:0] got, input logic [39:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic ms(input int n);
        repeat (n * CM) @(negedge i_clk);
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic t_static();
        logic [15:0] ec, ee;
        chk({o_block_version, o_user_struct_id, o_diag_len}, {16'h0101, 16'h8000, 3'h5});
        for (int i = 0; i < 26; i++) begin
            i_entry_idx = i[4:0];
            @(negedge i_clk);
            ec = i < 2 ? 16'h8000 : (i < 10 ? 16'(i - 1) : 16'((i - 10) / 2 + 1));
            ee = i < 2 ? 16'h0002 : (i < 10 ? 16'h0102 : (i % 2 ? 16'h0101 : 16'h0100));
            chk({o_entry_chan_num, o_entry_err_type}, {ec, ee});
        end
        chk(o_entry_props, 16'h0000);
    endtask
    task automatic t_sensor_low();
        cmd = 16'h0003;
        ms(1);
        i_sensor_supply_bad = 1'b1;
        @(negedge i_clk);
        chk(o_sensor_led_red, 1'b1);
        ms(3);
        chk({o_diag_image, o_lock, o_out_drive}, {40'h1, 16'h0, 16'h0003});
        chk({last_in, last_chan, last_err}, {1'b1, 16'h8000, 16'h0002});
        i_sensor_supply_bad = 1'b0;
        ms(3);
        chk({o_diag_image, last_in, last_chan}, {40'h0, 1'b0, 16'h8000});
    endtask
    task automatic t_act_low();
        cmd = 16'h0005;
        ms(2);
        i_actuator_supply_bad = 1'b1;
        ms(295);
        chk({o_actuator_led_red, o_lock}, {1'b0, 16'h0});
        ms(7);
        chk({o_actuator_led_red, o_lock, o_out_drive}, {1'b1, 16'h0005, 16'h0});
        chk(o_diag_image, 40'h2);
        i_actuator_supply_bad = 1'b0;
        ms(3);
        chk({o_diag_image, o_lock, last_in}, {40'h0, 16'h0005, 1'b0});
        i_lock_reset = 16'h0005;
        ms(1);
        i_lock_reset = 16'h0000;
        ms(1);
        chk({o_lock, o_out_drive}, {16'h0, 16'h0005});
    endtask
    task automatic t_short();
        i_sensor_short_raw = 8'h02;
        ms(4);
        chk(o_fault_present, 26'h0);
        ms(6);
        chk({o_fault_present, o_diag_image}, {26'h8, 40'h0});
        chk({last_in, last_chan, last_err}, {1'b1, 16'h0002, 16'h0102});
        i_sensor_short_raw = 8'h00;
        ms(3);
        chk({o_fault_present, last_in}, {26'h0, 1'b0});
    endtask
    task automatic t_chan();
        cmd = 16'h0070;
        ms(10);
        i_chan_fault_raw = 16'h0050;
        ms(95);
        chk(o_lock, 16'h0);
        ms(10);
        chk({o_lock, o_out_drive, o_fault_present}, {16'h0070, 16'h0, 26'h14000});
        chk(o_diag_image, 40'h00_5000_0008);
        i_chan_fault_raw = 16'h0000;
        ms(3);
        chk({o_lock, o_diag_image}, {16'h0070, 40'h0});
        i_lock_reset = 16'h0070;
        ms(1);
        i_lock_reset = 16'h0000;
        ms(1);
        chk(o_lock, 16'h0);
    endtask
    task automatic t_disabled();
        logic [7:0] c;
        c = count;
        i_diag_enable = 1'b0;
        i_sensor_supply_bad = 1'b1;
        ms(3);
        i_sensor_supply_bad = 1'b0;
        ms(3);
        chk({o_alarm_valid, count}, {1'b0, c});
        i_diag_enable = 1'b1;
    endtask
    initial begin
        forever #2.5 i_clk = ~i_clk;
    end
    // Run is about 1860 cycles; ceiling of 5000 leaves over two and a half times that
    always @(posedge i_clk) begin
        cyc++;
        if (cyc == 5000) begin
            n_mismatch++;
            finish_test();
        end
    end
    initial begin
        repeat (10) @(posedge i_clk);
        @(negedge i_clk);
        i_rst = 1'b0;
        ms(1);
        t_static();
        t_sensor_low();
        t_act_low();
        t_short();
        t_chan();
        t_disabled();
        finish_test();
    end
endmodule
`default_nettype wire
